// file: pwe_watchdog_event_manager.sv
// watchdog event manager: window timer, expiry and event tallies, reset selection
// ************************************************************
// ************************************************************
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps

module pwe_watchdog_event_manager
	import pwe_pkg::*;
#(
	parameter int TICK_CYCLES = PWE_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic host_watchdog_fail_in,
	input wire logic processor_reset_out_n,
	input wire logic off_mode,
	input wire logic standby_state,
	input wire logic [3:0] default_window_length_code,
	input wire logic [2:0] default_expiry_tally_limit,
	input wire logic [3:0] default_event_tally_limit,
	input wire logic window_mode_default,
	input wire logic timer_enable_default,
	input wire logic standby_timer_enable_default,
	input wire logic [PWE_ADDR_W-1:0] reg_addr,
	input wire logic [PWE_DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [PWE_DATA_W-1:0] reg_rdata,
	output logic soft_reset_req,
	output logic hard_reset_req,
	output logic fail_safe_req
);

	// ************************************************************
	// state
	// ************************************************************
	logic pin_s1_q, pin_s2_q, pin_s3_q;
	pwe_ctrl_t ctrl_q, ctrl_d;
	logic [3:0] window_length_code_q, window_length_code_d;
	logic window_mode_q, window_mode_d;
	logic [2:0] expiry_tally_limit_q, expiry_tally_limit_d;
	logic [3:0] event_tally_limit_q, event_tally_limit_d;
	logic [2:0] expiry_tally_q, expiry_tally_d;
	logic [3:0] event_tally_q, event_tally_d;
	logic refresh_pending_flag_q, refresh_pending_flag_d;
	logic armed_q, armed_d;
	pwe_state_t state_q, state_d;
	logic [PWE_MS_W-1:0] ms_cnt_q, ms_cnt_d;
	logic [PWE_TICK_W-1:0] tick_cnt_q, tick_cnt_d;
	logic [PWE_DATA_W-1:0] rdata_q, rdata_d;
	logic soft_q, soft_d, hard_q, hard_d, fs_q, fs_d;

	// decoded helpers
	logic run;
	logic tick;
	logic expire;
	logic [PWE_MS_W-1:0] dur_ms;
	logic [PWE_MS_W-1:0] half_ms;
	logic clear_req;
	logic early;
	logic refresh_ok;
	logic refresh_fail;
	logic [3:0] tally_sum;
	logic int_evt;
	logic pin_evt;
	logic any_evt;
	logic [3:0] evt_sum;
	logic fs_hit;
	logic ctrl_wr_ok;

	// ************************************************************
	// pin synchroniser
	// ************************************************************
	// two stages for metastability, third only for the edge
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
			pin_s3_q <= 1'b1;
		end else begin
			pin_s1_q <= host_watchdog_fail_in;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// ************************************************************
	// event and timer decode
	// ************************************************************
	// conditions shared by the next-state logic and the checks
	always_comb begin
		run = ctrl_q.timer_enable_bit && processor_reset_out_n && !off_mode
			&& (!standby_state || ctrl_q.standby_timer_enable);
		dur_ms = PWE_MS_ONE << window_length_code_q;
		half_ms = dur_ms >> 1;
		tick = (state_q == PWE_COUNT) && (tick_cnt_q == PWE_TICK_W'(TICK_CYCLES - 1));
		expire = tick && ((ms_cnt_q + PWE_MS_ONE) == dur_ms);
		clear_req = reg_write && (reg_addr == PWE_REG_STATUS) && reg_wdata[PWE_FLAG_BIT];
		early = window_mode_q && (ms_cnt_q < half_ms);
		refresh_ok = run && (state_q == PWE_COUNT) && refresh_pending_flag_q && clear_req && !early;
		refresh_fail = run && (state_q == PWE_COUNT) && ((refresh_pending_flag_q && clear_req && early)
			|| (expire && !(refresh_pending_flag_q && clear_req)));
		tally_sum = {1'b0, expiry_tally_q} + PWE_TALLY_STEP_UP;
		int_evt = refresh_fail && (tally_sum >= {1'b0, expiry_tally_limit_q});
		pin_evt = pin_s3_q && !pin_s2_q && !off_mode;
		any_evt = int_evt || pin_evt;
		evt_sum = (event_tally_q == PWE_EVT_MAX) ? event_tally_q : event_tally_q + 4'h1;
		fs_hit = any_evt && (evt_sum == event_tally_limit_q);
		ctrl_wr_ok = !ctrl_q.secure_en || armed_q;
	end

	// ************************************************************
	// next state
	// ************************************************************
	// registers, tallies, timer and reset requests
	always_comb begin
		ctrl_d = ctrl_q;
		window_length_code_d = window_length_code_q;
		window_mode_d = window_mode_q;
		expiry_tally_limit_d = expiry_tally_limit_q;
		event_tally_limit_d = event_tally_limit_q;
		expiry_tally_d = expiry_tally_q;
		event_tally_d = event_tally_q;
		refresh_pending_flag_d = refresh_pending_flag_q;
		armed_d = armed_q;
		state_d = state_q;
		ms_cnt_d = ms_cnt_q;
		tick_cnt_d = tick_cnt_q;
		rdata_d = '0;
		soft_d = 1'b0;
		hard_d = 1'b0;
		fs_d = 1'b0;

		// register writes
		if (reg_write) begin
			armed_d = 1'b0;
			unique case (reg_addr)
				PWE_REG_CTRL: begin
					ctrl_d.pin_event_reset_type = reg_wdata[2];
					if (ctrl_wr_ok) begin
						ctrl_d.timer_enable_bit = reg_wdata[0];
						ctrl_d.standby_timer_enable = reg_wdata[1];
						ctrl_d.secure_en = reg_wdata[3];
					end
				end
				PWE_REG_CONFIG: window_length_code_d = reg_wdata[3:0];
				PWE_REG_LIMITS: begin
					expiry_tally_limit_d = reg_wdata[2:0];
					event_tally_limit_d = reg_wdata[PWE_EVLIM_LSB +: 4];
				end
				PWE_REG_EVENT: event_tally_d = '0;
				PWE_REG_UNLOCK: armed_d = (reg_wdata == PWE_UNLOCK_KEY);
				default: ;
			endcase
			if (clear_req) begin
				refresh_pending_flag_d = 1'b0;
			end
		end

		// register reads, data shown next cycle
		if (reg_read) begin
			unique case (reg_addr)
				PWE_REG_CTRL: rdata_d = ctrl_q;
				PWE_REG_CONFIG: rdata_d = {3'h0, window_mode_q, window_length_code_q};
				PWE_REG_STATUS: rdata_d = {1'b0, expiry_tally_q, 3'h0, refresh_pending_flag_q};
				PWE_REG_LIMITS: rdata_d = {event_tally_limit_q, 1'b0, expiry_tally_limit_q};
				PWE_REG_EVENT: rdata_d = {4'h0, event_tally_q};
				default: rdata_d = '0;
			endcase
		end

		// timer
		unique case (state_q)
			PWE_IDLE: begin
				ms_cnt_d = '0;
				tick_cnt_d = '0;
				if (run) begin
					state_d = PWE_COUNT;
					refresh_pending_flag_d = 1'b1;
				end
			end
			PWE_COUNT: begin
				if (!run) begin
					state_d = PWE_IDLE;
					ms_cnt_d = '0;
					tick_cnt_d = '0;
					refresh_pending_flag_d = 1'b0;
				end else if (refresh_ok || refresh_fail || any_evt
					|| (window_length_code_d != window_length_code_q)) begin
					ms_cnt_d = '0;
					tick_cnt_d = '0;
					refresh_pending_flag_d = 1'b1;
				end else if (tick) begin
					tick_cnt_d = '0;
					ms_cnt_d = ms_cnt_q + PWE_MS_ONE;
				end else begin
					tick_cnt_d = tick_cnt_q + 1'b1;
				end
			end
		endcase

		// expiry tally
		if (refresh_ok && (expiry_tally_q != 3'h0)) begin
			expiry_tally_d = expiry_tally_q - PWE_TALLY_STEP_DN;
		end
		if (refresh_fail) begin
			expiry_tally_d = tally_sum[2:0];
		end

		// event start and reset choice
		if (any_evt) begin
			expiry_tally_d = '0;
			event_tally_d = evt_sum;
			if (fs_hit) begin
				fs_d = 1'b1;
			end else if (int_evt || ctrl_q.pin_event_reset_type) begin
				hard_d = 1'b1;
			end else begin
				soft_d = 1'b1;
			end
		end

		// off mode: defaults reload, timer, flag, tallies and unlock restart
		if (off_mode) begin
			ctrl_d.timer_enable_bit = timer_enable_default;
			ctrl_d.standby_timer_enable = standby_timer_enable_default;
			window_length_code_d = default_window_length_code;
			window_mode_d = window_mode_default;
			expiry_tally_limit_d = default_expiry_tally_limit;
			event_tally_limit_d = default_event_tally_limit;
			expiry_tally_d = '0;
			event_tally_d = '0;
			refresh_pending_flag_d = 1'b0;
			armed_d = 1'b0;
			state_d = PWE_IDLE;
			ms_cnt_d = '0;
			tick_cnt_d = '0;
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	// flip-flops only; reset clears every register but the pin synchroniser (set to one) to zero rather than loading the defaults
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= '0;
			window_length_code_q <= '0;
			window_mode_q <= 1'b0;
			expiry_tally_limit_q <= '0;
			event_tally_limit_q <= '0;
			expiry_tally_q <= '0;
			event_tally_q <= '0;
			refresh_pending_flag_q <= 1'b0;
			armed_q <= 1'b0;
			state_q <= PWE_IDLE;
			ms_cnt_q <= '0;
			tick_cnt_q <= '0;
			rdata_q <= '0;
			soft_q <= 1'b0;
			hard_q <= 1'b0;
			fs_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			window_length_code_q <= window_length_code_d;
			window_mode_q <= window_mode_d;
			expiry_tally_limit_q <= expiry_tally_limit_d;
			event_tally_limit_q <= event_tally_limit_d;
			expiry_tally_q <= expiry_tally_d;
			event_tally_q <= event_tally_d;
			refresh_pending_flag_q <= refresh_pending_flag_d;
			armed_q <= armed_d;
			state_q <= state_d;
			ms_cnt_q <= ms_cnt_d;
			tick_cnt_q <= tick_cnt_d;
			rdata_q <= rdata_d;
			soft_q <= soft_d;
			hard_q <= hard_d;
			fs_q <= fs_d;
		end
	end

	// outputs straight from flip-flops
	assign reg_rdata = rdata_q;
	assign soft_reset_req = soft_q;
	assign hard_reset_req = hard_q;
	assign fail_safe_req = fs_q;

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_timer_start;
		(state_q == PWE_IDLE) ##1 (state_q == PWE_COUNT);
	endsequence

	sequence s_pin_fall;
		pin_s2_q ##1 !pin_s2_q;
	endsequence

	a_pin_soft_reset: assert property (@(posedge clk) disable iff (reset)
		s_pin_fall ##0 (!off_mode && !ctrl_q.pin_event_reset_type && !int_evt && !fs_hit)
		|=> soft_reset_req && !hard_reset_req)
		else $error("pin event did not give a soft reset");

	a_int_hard_reset: assert property (@(posedge clk) disable iff (reset)
		(int_evt && !fs_hit) |=> hard_reset_req && !soft_reset_req && (expiry_tally_q == 3'h0))
		else $error("internal event did not give a hard reset");

	a_flag_on_start: assert property (@(posedge clk) disable iff (reset)
		s_timer_start |-> refresh_pending_flag_q && (ms_cnt_q == '0))
		else $error("timer started without pending flag");

	a_tally_up_two: assert property (@(posedge clk) disable iff (reset)
		(refresh_fail && !any_evt && !off_mode) |=> (expiry_tally_q == $past(expiry_tally_q) + 3'h2)
		&& (ms_cnt_q == '0) && refresh_pending_flag_q)
		else $error("failed refresh did not add two");

	a_tally_down_one: assert property (@(posedge clk) disable iff (reset)
		(refresh_ok && !any_evt && !off_mode && (expiry_tally_q != 3'h0))
		|=> (expiry_tally_q == $past(expiry_tally_q) - 3'h1) && (ms_cnt_q == '0))
		else $error("valid refresh did not subtract one");

	a_off_idle: assert property (@(posedge clk) disable iff (reset)
		off_mode |=> (state_q == PWE_IDLE) && (event_tally_q == '0) && (ms_cnt_q == '0))
		else $error("off mode did not clear timer and tallies");

	a_count_bound: assert property (@(posedge clk) disable iff (reset)
		ms_cnt_q < dur_ms)
		else $error("timer ran past its duration");

	a_enable_gate: assert property (@(posedge clk) disable iff (reset)
		(!ctrl_q.timer_enable_bit || (standby_state && !ctrl_q.standby_timer_enable))
		|=> (state_q == PWE_IDLE))
		else $error("timer ran while disabled");

	a_secure_block: assert property (@(posedge clk) disable iff (reset)
		(reg_write && (reg_addr == PWE_REG_CTRL) && ctrl_q.secure_en && !armed_q && !off_mode)
		|=> (ctrl_q.timer_enable_bit == $past(ctrl_q.timer_enable_bit))
		&& (ctrl_q.standby_timer_enable == $past(ctrl_q.standby_timer_enable)))
		else $error("enable changed without unlock");

	a_duration_restart: assert property (@(posedge clk) disable iff (reset)
		(state_q == PWE_COUNT && run && reg_write && (reg_addr == PWE_REG_CONFIG)
		&& (reg_wdata[3:0] != window_length_code_q)) |=> (ms_cnt_q == '0) && (tick_cnt_q == '0))
		else $error("duration change did not restart timer");

	a_fail_safe: assert property (@(posedge clk) disable iff (reset)
		fs_hit |=> fail_safe_req && !hard_reset_req && !soft_reset_req && (event_tally_q == $past(event_tally_limit_q)))
		else $error("event limit did not request fail-safe");

endmodule

// file: pwe_pkg.sv
// constants, register map and types shared by the watchdog event manager
package pwe_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int PWE_CLK_PERIOD_NS = 100; // 10 MHz core clock
	localparam int PWE_TICK_NS = 1000000; // one millisecond in ns
	localparam int PWE_TICK_CYCLES = PWE_TICK_NS / PWE_CLK_PERIOD_NS;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int PWE_ADDR_W = 3;
	localparam int PWE_DATA_W = 8;
	localparam int PWE_MS_W = 16;
	localparam int PWE_TICK_W = 14;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [2:0] PWE_REG_CTRL = 3'h0;
	localparam logic [2:0] PWE_REG_CONFIG = 3'h1;
	localparam logic [2:0] PWE_REG_STATUS = 3'h2;
	localparam logic [2:0] PWE_REG_LIMITS = 3'h3;
	localparam logic [2:0] PWE_REG_EVENT = 3'h4;
	localparam logic [2:0] PWE_REG_UNLOCK = 3'h5;

	// ************************************************************
	// field positions and values
	// ************************************************************
	localparam int PWE_FLAG_BIT = 0; // status: refresh pending
	localparam int PWE_TALLY_LSB = 4; // status: expiry tally
	localparam int PWE_WINMODE_BIT = 4; // config: window mode
	localparam int PWE_EVLIM_LSB = 4; // limits: event tally limit
	localparam logic [7:0] PWE_UNLOCK_KEY = 8'ha5;
	localparam logic [3:0] PWE_TALLY_STEP_UP = 4'h2;
	localparam logic [2:0] PWE_TALLY_STEP_DN = 3'h1;
	localparam logic [3:0] PWE_EVT_MAX = 4'hf;
	localparam logic [15:0] PWE_MS_ONE = 16'h0001;

	// control register layout, msb first
	typedef struct packed {
		logic [3:0] spare;
		logic secure_en; // bit 3
		logic pin_event_reset_type; // bit 2, 1 = hard
		logic standby_timer_enable; // bit 1
		logic timer_enable_bit; // bit 0
	} pwe_ctrl_t;

	typedef enum logic [0:0] {PWE_IDLE, PWE_COUNT} pwe_state_t;

endpackage

// file: pwe_host_model.sv
// host processor model: register port master and watchdog fail pin
`timescale 1ns/1ps

module pwe_host_model
	import pwe_pkg::*;
(
	input wire logic clk,
	input wire logic [PWE_DATA_W-1:0] reg_rdata,
	output logic [PWE_ADDR_W-1:0] reg_addr,
	output logic [PWE_DATA_W-1:0] reg_wdata,
	output logic reg_write,
	output logic reg_read,
	output logic host_watchdog_fail_in
);
	// ************************************************************
	// idle levels and bus cycles
	// ************************************************************
	// strobes low, fail pin idles high
	initial begin
		reg_addr = '0;
		reg_wdata = '0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		host_watchdog_fail_in = 1'b1;
	end

	// one-cycle write; data is scrambled afterwards so nothing leans on a held value
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		reg_wdata <= ~d;
	endtask

	// one-cycle read; data stands in the following cycle only
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask

	// refresh by writing one to the pending flag
	task automatic refresh();
		wr(PWE_REG_STATUS, 8'h01);
	endtask

	// unlock then control write
	task automatic secure_wr(input logic [7:0] d);
		wr(PWE_REG_UNLOCK, PWE_UNLOCK_KEY);
		wr(PWE_REG_CTRL, d);
	endtask

	// a high-to-low edge signals a host watchdog failure
	task automatic set_pin(input logic v);
		@(posedge clk);
		host_watchdog_fail_in <= v;
	endtask
endmodule

// file: pwe_watchdog_event_manager_tb.sv
// self-checking testbench of the watchdog event manager
`timescale 1ns/1ps

module pwe_watchdog_event_manager_tb;
	import pwe_pkg::*;
	logic clk = 1'b0;
	logic reset, pin, cpu_rst_n, off_mode, standby_state;
	logic [3:0] def_code, def_evlim;
	logic [2:0] def_exlim;
	logic def_win, def_en, def_sen;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, d;
	logic wr_s, rd_s, soft_r, hard_r, fs_r;
	logic [2:0] ev;
	int n, bad_count, n_checks;

	pwe_watchdog_event_manager #(.TICK_CYCLES(4)) dut (.clk(clk), .reset(reset),
		.host_watchdog_fail_in(pin), .processor_reset_out_n(cpu_rst_n), .off_mode(off_mode),
		.standby_state(standby_state), .default_window_length_code(def_code),
		.default_expiry_tally_limit(def_exlim), .default_event_tally_limit(def_evlim),
		.window_mode_default(def_win), .timer_enable_default(def_en),
		.standby_timer_enable_default(def_sen), .reg_addr(addr), .reg_wdata(wdata),
		.reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata), .soft_reset_req(soft_r),
		.hard_reset_req(hard_r), .fail_safe_req(fs_r));

	pwe_host_model h (.clk(clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wdata(wdata),
		.reg_write(wr_s), .reg_read(rd_s), .host_watchdog_fail_in(pin));

	// ************************************************************
	// clock, compare and closing
	// ************************************************************
	always #50 clk = ~clk;

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		if (bad_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// bounded wait for any reset or fail-safe pulse, as {fail_safe, hard, soft}
	task automatic wait_evt();
		for (n = 0; n < 80; n++) begin
			@(negedge clk);
			ev = {fs_r, hard_r, soft_r};
			if (ev != 3'b000) break;
		end
		if (n == 80) begin
			bad_count++;
			end_of_test();
		end
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	// expiry at limit two, then tally climb and refresh in single-ended mode
	task automatic expiry_path();
		wait_evt();
		check("expiry event kind", {5'h0, ev}, 8'h02);
		check("expiry time", 8'(n >= 31 && n <= 37), 8'h01);
		h.rd(PWE_REG_EVENT, d);
		check("event tally", d, 8'h01);
		h.rd(PWE_REG_CONFIG, d);
		check("config default", d, 8'h03);
		h.rd(PWE_REG_STATUS, d);
		check("flag after restart", d, 8'h01);
		h.wr(PWE_REG_LIMITS, 8'hf7);
		h.wr(PWE_REG_CONFIG, 8'h02);
		for (int i = 0; i < 20 && d[6:4] !== 3'h2; i++) begin
			h.rd(PWE_REG_STATUS, d);
		end
		check("tally after miss", {5'h0, d[6:4]}, 8'h02);
		h.refresh();
		h.rd(PWE_REG_STATUS, d);
		check("tally after refresh", d, 8'h11);
	endtask

	// standby stops the timer; pin events by reset type; event limit gives fail-safe
	task automatic standby_pin_path();
		h.wr(PWE_REG_CTRL, 8'h01);
		standby_state <= 1'b1;
		repeat (2) @(posedge clk);
		h.rd(PWE_REG_STATUS, d);
		check("standby flag", d & 8'h01, 8'h00);
		for (int k = 0; k < 2; k++) begin
			h.wr(PWE_REG_CTRL, k ? 8'h05 : 8'h01);
			h.set_pin(1'b0);
			wait_evt();
			check("pin event kind", {5'h0, ev}, k ? 8'h02 : 8'h01);
			h.set_pin(1'b1);
			repeat (4) @(posedge clk);
		end
		h.rd(PWE_REG_EVENT, d);
		check("event tally count", d, 8'h03);
		h.wr(PWE_REG_EVENT, 8'h00);
		h.wr(PWE_REG_LIMITS, 8'h17);
		h.set_pin(1'b0);
		wait_evt();
		check("fail-safe kind", {5'h0, ev}, 8'h04);
		h.set_pin(1'b1);
		standby_state <= 1'b0;
	endtask

	// off mode reload, idle until processor reset release, window mode refreshes
	task automatic window_path();
		def_win <= 1'b1;
		def_exlim <= 3'h7;
		def_code <= 4'h4;
		def_evlim <= 4'h2;
		def_sen <= 1'b1;
		cpu_rst_n <= 1'b0;
		off_mode <= 1'b1;
		repeat (2) @(posedge clk);
		off_mode <= 1'b0;
		repeat (40) @(posedge clk);
		h.rd(PWE_REG_STATUS, d);
		check("idle status", d, 8'h00);
		h.rd(PWE_REG_EVENT, d);
		check("event tally after off", d, 8'h00);
		h.rd(PWE_REG_CONFIG, d);
		check("config reload", d, 8'h14);
		h.rd(PWE_REG_LIMITS, d);
		check("limits reload", d, 8'h27);
		h.rd(PWE_REG_CTRL, d);
		check("ctrl reload", d, 8'h07);
		@(posedge clk);
		cpu_rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		h.refresh();
		h.rd(PWE_REG_STATUS, d);
		check("early clear", d, 8'h21);
		repeat (40) @(posedge clk);
		h.refresh();
		h.rd(PWE_REG_STATUS, d);
		check("late clear", d, 8'h11);
	endtask

	// protected enables, unlock sequence, unmapped read
	task automatic secure_path();
		h.wr(PWE_REG_CTRL, 8'h09);
		h.wr(PWE_REG_CTRL, 8'h08);
		h.rd(PWE_REG_CTRL, d);
		check("locked ctrl", d, 8'h09);
		h.secure_wr(8'h0a);
		h.rd(PWE_REG_CTRL, d);
		check("unlocked ctrl", d, 8'h0a);
		h.rd(3'h6, d);
		check("unmapped read", d, 8'h00);
	endtask

	// reset, strap load in off mode, then the scenarios in turn
	initial begin
		reset = 1'b1;
		off_mode = 1'b1;
		standby_state = 1'b0;
		cpu_rst_n = 1'b1;
		def_code = 4'h3;
		def_exlim = 3'h2;
		def_evlim = 4'hf;
		def_win = 1'b0;
		def_en = 1'b1;
		def_sen = 1'b0;
		bad_count = 0;
		n_checks = 0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		off_mode <= 1'b0;
		expiry_path();
		standby_pin_path();
		window_path();
		secure_path();
		end_of_test();
	end
endmodule
